/* logic/bra_pkg.sv */
package bra_pkg;

   // Function codes, BCD coded as they appear in the program
   localparam logic [7:0]  FN_BIN_ADD    = 8'h50;
   localparam logic [7:0]  FN_BIN_SUB    = 8'h51;
   localparam logic [7:0]  FN_ROOT       = 8'h72;
   localparam logic [7:0]  FN_CARRY_SET  = 8'h40;
   localparam logic [7:0]  FN_CARRY_WIPE = 8'h41;

   // Special relay bit addresses of the arithmetic flags
   localparam logic [15:0] RELAY_OVERFLOW  = 16'h633C;
   localparam logic [15:0] RELAY_UNDERFLOW = 16'h633D;
   localparam logic [15:0] RELAY_CARRY     = 16'h63A0;

   // Signed 16-bit range, held at 18 bits for the range test
   localparam logic signed [17:0] SIGNED_MAX = 18'sh07FFF;
   localparam logic signed [17:0] SIGNED_MIN = 18'sh38000;

   localparam int unsigned WORD_BITS  = 16;
   localparam int unsigned WORD_DIGITS = 4;
   localparam int unsigned ROOT_BITS  = 14;
   localparam int unsigned RAD_BITS   = 27;
   localparam logic [26:0] HI_WORD_WEIGHT = 27'h0002710;
   localparam logic [3:0]  BCD_MAX_DIGIT  = 4'h9;
   localparam logic [3:0]  DABBLE_LIMIT   = 4'h5;
   localparam logic [3:0]  DABBLE_ADJ     = 4'h3;

   // Operand slots for indirect addressing
   localparam int unsigned SLOT_A = 0;
   localparam int unsigned SLOT_B = 1;
   localparam int unsigned SLOT_R = 2;

   typedef struct packed {
      logic [7:0]  func;
      logic        exec_cond;
      logic [15:0] src_a;
      logic [15:0] src_b;
      logic [2:0]  ind_used;
      logic [15:0] ptr_a;
      logic [15:0] ptr_b;
      logic [15:0] ptr_r;
   } bra_req_t;

   typedef struct packed {
      logic fault_flag;
      logic zero_flag;
      logic carry_flag;
      logic overflow_flag;
      logic underflow_flag;
      logic sign_flag;
   } bra_flags_t;

   localparam bra_flags_t FLAGS_RESET = 6'h00;

endpackage : bra_pkg

/* logic/bra_bcd_word_chk.sv */
`timescale 1ns/10ps
`default_nettype none

module bra_bcd_word_chk #(
   parameter int unsigned DIGITS = 4
) (
   input  wire logic [4*DIGITS-1:0] word_i,
   output logic                     valid_o,
   output logic [13:0]              value_o
);

   initial begin
      if (DIGITS != 4) begin
         $error("bra_bcd_word_chk serves four-digit words only");
      end
   end

   always_comb begin
      valid_o = 1'b1;
      value_o = 14'h0000;
      for (int d = DIGITS - 1; d >= 0; d--) begin
         if (word_i[4*d +: 4] > bra_pkg::BCD_MAX_DIGIT) begin
            valid_o = 1'b0;
         end
         value_o = 14'((value_o << 3) + (value_o << 1) + {10'h000, word_i[4*d +: 4]});
      end
   end

endmodule : bra_bcd_word_chk

`default_nettype wire

/* logic/bra_root_unit.sv */
`timescale 1ns/10ps
`default_nettype none

module bra_root_unit (
   input  wire logic        sys_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        start_i,
   input  wire logic [26:0] radicand_i,
   output logic             done_o,
   output logic [15:0]      root_bcd_o
);

   typedef enum logic [1:0] {
      RT_IDLE  = 2'b00,
      RT_ROOT  = 2'b01,
      RT_TOBCD = 2'b11,
      RT_FIN   = 2'b10
   } bra_rt_state_t;

   bra_rt_state_t state, next_state;
   logic [26:0]   rad, next_rad;
   logic [13:0]   root, next_root;
   logic [3:0]    idx, next_idx;
   logic [15:0]   bcd, next_bcd;
   logic [13:0]   trial;
   logic [27:0]   trial_sq;
   logic [15:0]   adj;

   always_comb begin
      next_state = state;
      next_rad   = rad;
      next_root  = root;
      next_idx   = idx;
      next_bcd   = bcd;
      trial      = root | (14'h0001 << idx);
      trial_sq   = {14'h0000, trial} * {14'h0000, trial};
      adj        = bcd;
      for (int d = 0; d < 4; d++) begin
         if (bcd[4*d +: 4] >= bra_pkg::DABBLE_LIMIT) begin
            adj[4*d +: 4] = bcd[4*d +: 4] + bra_pkg::DABBLE_ADJ;
         end
      end
      case (state)
         RT_IDLE: begin
            if (start_i) begin
               next_rad   = radicand_i;
               next_root  = 14'h0000;
               next_idx   = 4'(bra_pkg::ROOT_BITS - 1);
               next_state = RT_ROOT;
            end
         end
         RT_ROOT: begin
            // Bitwise root keeps only the integer part
            if (trial_sq <= {1'b0, rad}) begin
               next_root = trial;
            end
            if (idx == 4'h0) begin
               next_idx   = 4'(bra_pkg::ROOT_BITS - 1);
               next_bcd   = 16'h0000;
               next_state = RT_TOBCD;
            end else begin
               next_idx = idx - 4'h1;
            end
         end
         RT_TOBCD: begin
            // Binary root back to four BCD digits
            next_bcd = {adj[14:0], root[idx]};
            if (idx == 4'h0) begin
               next_state = RT_FIN;
            end else begin
               next_idx = idx - 4'h1;
            end
         end
         RT_FIN: begin
            next_state = RT_IDLE;
         end
         default: begin
            next_state = RT_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= RT_IDLE;
         rad   <= 27'h0000000;
         root  <= 14'h0000;
         idx   <= 4'h0;
         bcd   <= 16'h0000;
      end else begin
         state <= next_state;
         rad   <= next_rad;
         root  <= next_root;
         idx   <= next_idx;
         bcd   <= next_bcd;
      end
   end

   assign done_o     = (state == RT_FIN);
   assign root_bcd_o = bcd;

endmodule : bra_root_unit

`default_nettype wire

/* logic/bra_alu.sv */
`timescale 1ns/10ps
`default_nettype none

module bra_alu #(
   parameter int unsigned DM_WORDS = 6144
) (
   input  wire logic                sys_clk_i,
   input  wire logic                rstn_i,
   input  wire logic                req_valid_i,
   input  wire bra_pkg::bra_req_t   req_i,
   output logic                     req_ready_o,
   output logic                     done_o,
   output logic                     res_we_o,
   output logic [15:0]              res_word_o,
   output bra_pkg::bra_flags_t      flags_o,
   input  wire logic [15:0]         relay_addr_i,
   output logic                     relay_bit_o
);

   initial begin
      if (DM_WORDS < 2 || DM_WORDS > 10000) begin
         $error("DM_WORDS must lie in 2..10000");
      end
   end

   typedef enum logic {
      ST_IDLE      = 1'b0,
      ST_ROOT_WAIT = 1'b1
   } bra_state_t;

   bra_state_t          state, next_state;
   bra_pkg::bra_flags_t flags, next_flags;
   logic [15:0]         res_word, next_res_word;
   logic                res_we, next_res_we;
   logic                done, next_done;
   logic                relay_bit, next_relay_bit;

   logic                root_start;
   logic                root_done;
   logic [15:0]         root_bcd;
   logic [26:0]         radicand;

   logic [2:0]          ptr_valid;
   logic [13:0]         ptr_val [3];
   logic [2:0]          ptr_ok;
   logic                ind_ok;
   logic                src_lo_valid, src_hi_valid;
   logic [13:0]         src_lo_val, src_hi_val;

   logic                accept;
   logic                cy_in;
   logic [16:0]         sum_full;
   logic [16:0]         sub_rhs;
   logic [16:0]         diff_full;
   logic signed [17:0]  s_sum;
   logic signed [17:0]  s_diff;
   logic                is_root;

   // Pointer checks for the three operand slots
   bra_bcd_word_chk #(.DIGITS(4)) u_ptr_a_chk (
      .word_i  (req_i.ptr_a),
      .valid_o (ptr_valid[bra_pkg::SLOT_A]),
      .value_o (ptr_val[bra_pkg::SLOT_A])
   );
   bra_bcd_word_chk #(.DIGITS(4)) u_ptr_b_chk (
      .word_i  (req_i.ptr_b),
      .valid_o (ptr_valid[bra_pkg::SLOT_B]),
      .value_o (ptr_val[bra_pkg::SLOT_B])
   );
   bra_bcd_word_chk #(.DIGITS(4)) u_ptr_r_chk (
      .word_i  (req_i.ptr_r),
      .valid_o (ptr_valid[bra_pkg::SLOT_R]),
      .value_o (ptr_val[bra_pkg::SLOT_R])
   );

   // Radicand words: src_a low four digits, src_b high four digits
   bra_bcd_word_chk #(.DIGITS(4)) u_src_lo_chk (
      .word_i  (req_i.src_a),
      .valid_o (src_lo_valid),
      .value_o (src_lo_val)
   );
   bra_bcd_word_chk #(.DIGITS(4)) u_src_hi_chk (
      .word_i  (req_i.src_b),
      .valid_o (src_hi_valid),
      .value_o (src_hi_val)
   );

   bra_root_unit u_root (
      .sys_clk_i  (sys_clk_i),
      .rstn_i     (rstn_i),
      .start_i    (root_start),
      .radicand_i (radicand),
      .done_o     (root_done),
      .root_bcd_o (root_bcd)
   );

   assign radicand = 27'({13'h0000, src_hi_val} * bra_pkg::HI_WORD_WEIGHT)
                     + {13'h0000, src_lo_val};

   assign is_root = (req_i.func == bra_pkg::FN_ROOT);

   always_comb begin
      for (int s = 0; s < 3; s++) begin
         ptr_ok[s] = !req_i.ind_used[s]
                     || (ptr_valid[s] && ({18'h00000, ptr_val[s]} < DM_WORDS));
      end
      // Root reads the word after the pointed one as well
      if (is_root && req_i.ind_used[bra_pkg::SLOT_A]
          && ({18'h00000, ptr_val[bra_pkg::SLOT_A]} + 32'h1 >= DM_WORDS)) begin
         ptr_ok[bra_pkg::SLOT_A] = 1'b0;
      end
      ind_ok = &ptr_ok;
   end

   // Add and subtract datapath
   always_comb begin
      cy_in     = flags.carry_flag;
      sum_full  = {1'b0, req_i.src_a} + {1'b0, req_i.src_b} + {16'h0000, cy_in};
      sub_rhs   = {1'b0, req_i.src_b} + {16'h0000, cy_in};
      diff_full = {1'b0, req_i.src_a} - sub_rhs;
      s_sum     = $signed({{2{req_i.src_a[15]}}, req_i.src_a})
                  + $signed({{2{req_i.src_b[15]}}, req_i.src_b})
                  + $signed({17'h00000, cy_in});
      s_diff    = $signed({{2{req_i.src_a[15]}}, req_i.src_a})
                  - $signed({{2{req_i.src_b[15]}}, req_i.src_b})
                  - $signed({17'h00000, cy_in});
   end

   assign accept = req_valid_i && (state == ST_IDLE);

   always_comb begin
      next_state    = state;
      next_flags    = flags;
      next_res_word = res_word;
      next_res_we   = 1'b0;
      next_done     = 1'b0;
      root_start    = 1'b0;
      case (state)
         ST_IDLE: begin
            if (accept) begin
               next_done = 1'b1;
               if (req_i.exec_cond) begin
                  case (req_i.func)
                     bra_pkg::FN_BIN_ADD: begin
                        if (!ind_ok) begin
                           next_flags.fault_flag = 1'b1;
                        end else begin
                           next_flags.fault_flag     = 1'b0;
                           next_res_word             = sum_full[15:0];
                           next_res_we               = 1'b1;
                           next_flags.carry_flag     = sum_full[16];
                           next_flags.zero_flag      = (sum_full[15:0] == 16'h0000);
                           next_flags.overflow_flag  = (s_sum > bra_pkg::SIGNED_MAX);
                           next_flags.underflow_flag = (s_sum < bra_pkg::SIGNED_MIN);
                           next_flags.sign_flag      = sum_full[15];
                        end
                     end
                     bra_pkg::FN_BIN_SUB: begin
                        if (!ind_ok) begin
                           next_flags.fault_flag = 1'b1;
                        end else begin
                           next_flags.fault_flag     = 1'b0;
                           // Wrapped difference is the two's complement form
                           next_res_word             = diff_full[15:0];
                           next_res_we               = 1'b1;
                           next_flags.carry_flag     = ({1'b0, req_i.src_a} < sub_rhs);
                           next_flags.zero_flag      = (diff_full[15:0] == 16'h0000);
                           next_flags.overflow_flag  = (s_diff > bra_pkg::SIGNED_MAX);
                           next_flags.underflow_flag = (s_diff < bra_pkg::SIGNED_MIN);
                           next_flags.sign_flag      = diff_full[15];
                        end
                     end
                     bra_pkg::FN_ROOT: begin
                        if (!ind_ok || !src_lo_valid || !src_hi_valid) begin
                           next_flags.fault_flag = 1'b1;
                        end else begin
                           next_flags.fault_flag = 1'b0;
                           root_start            = 1'b1;
                           next_done             = 1'b0;
                           next_state            = ST_ROOT_WAIT;
                        end
                     end
                     bra_pkg::FN_CARRY_SET: begin
                        next_flags.carry_flag = 1'b1;
                     end
                     bra_pkg::FN_CARRY_WIPE: begin
                        next_flags.carry_flag = 1'b0;
                     end
                     default: begin
                        next_flags = flags;
                     end
                  endcase
               end
            end
         end
         ST_ROOT_WAIT: begin
            if (root_done) begin
               next_res_word        = root_bcd;
               next_res_we          = 1'b1;
               next_flags.zero_flag = (root_bcd == 16'h0000);
               next_done            = 1'b1;
               next_state           = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Relay bit read port
   always_comb begin
      case (relay_addr_i)
         bra_pkg::RELAY_OVERFLOW:  next_relay_bit = next_flags.overflow_flag;
         bra_pkg::RELAY_UNDERFLOW: next_relay_bit = next_flags.underflow_flag;
         bra_pkg::RELAY_CARRY:     next_relay_bit = next_flags.carry_flag;
         default:                  next_relay_bit = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state     <= ST_IDLE;
         flags     <= bra_pkg::FLAGS_RESET;
         res_word  <= 16'h0000;
         res_we    <= 1'b0;
         done      <= 1'b0;
         relay_bit <= 1'b0;
      end else begin
         state     <= next_state;
         flags     <= next_flags;
         res_word  <= next_res_word;
         res_we    <= next_res_we;
         done      <= next_done;
         relay_bit <= next_relay_bit;
      end
   end

   assign req_ready_o = (state == ST_IDLE);
   assign done_o      = done;
   assign res_we_o    = res_we;
   assign res_word_o  = res_word;
   assign flags_o     = flags;
   assign relay_bit_o = relay_bit;

endmodule : bra_alu

`default_nettype wire

/* verif/bra_alu_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module bra_alu_sva #(
   parameter int unsigned DM_WORDS = 6144
) (
   input  wire logic                sys_clk_i,
   input  wire logic                rstn_i,
   input  wire logic                req_valid_i,
   input  wire bra_pkg::bra_req_t   req_i,
   input  wire logic                req_ready_o,
   input  wire logic                done_o,
   input  wire logic                res_we_o,
   input  wire logic [15:0]         res_word_o,
   input  wire bra_pkg::bra_flags_t flags_o,
   input  wire logic [15:0]         relay_addr_i,
   input  wire logic                relay_bit_o
);
   function automatic logic bcd(input logic [15:0] w);
      return w[3:0] < 4'hA && w[7:4] < 4'hA && w[11:8] < 4'hA && w[15:12] < 4'hA;
   endfunction : bcd
   function automatic logic pok(input logic [15:0] p);
      return bcd(p) && (p[15:12] * 1000 + p[11:8] * 100 + p[7:4] * 10 + p[3:0]) < DM_WORDS;
   endfunction : pok
   logic               go;
   logic               arith;
   logic               sub;
   logic               pbad;
   logic               rbad;
   logic [16:0]        res17;
   logic signed [17:0] sa;
   logic signed [17:0] sb;
   logic signed [17:0] c;
   logic signed [17:0] val;
   assign go    = req_valid_i && req_ready_o && req_i.exec_cond;
   assign sub   = req_i.func == bra_pkg::FN_BIN_SUB;
   assign arith = sub || req_i.func == bra_pkg::FN_BIN_ADD;
   assign pbad  = (req_i.ind_used[0] && !pok(req_i.ptr_a)) ||
                  (req_i.ind_used[1] && !pok(req_i.ptr_b)) ||
                  (req_i.ind_used[2] && !pok(req_i.ptr_r));
   assign rbad  = !bcd(req_i.src_a) || !bcd(req_i.src_b);
   assign res17 = sub ? {1'b0, req_i.src_a} - {1'b0, req_i.src_b} - {16'h0000, flags_o.carry_flag}
                      : {1'b0, req_i.src_a} + {1'b0, req_i.src_b} + {16'h0000, flags_o.carry_flag};
   assign sa    = {{2{req_i.src_a[15]}}, req_i.src_a};
   assign sb    = {{2{req_i.src_b[15]}}, req_i.src_b};
   assign c     = {17'h00000, flags_o.carry_flag};
   assign val   = sub ? sa - sb - c : sa + sb + c;
   default clocking dc @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   skip_quiet_a: assert property (req_valid_i && req_ready_o && !req_i.exec_cond
      |=> done_o && !res_we_o && $stable(flags_o) && $stable(res_word_o)) else $error("skip changed state");
   arith_word_a: assert property (go && arith && !pbad |=> res_we_o
      && {flags_o.carry_flag, res_word_o} == $past(res17)) else $error("arith result wrong");
   arith_sign_a: assert property (go && arith && !pbad |=> flags_o.sign_flag == res_word_o[15])
      else $error("sign flag wrong");
   signed_range_a: assert property (go && arith && !pbad |=>
      flags_o.overflow_flag == $past(val > bra_pkg::SIGNED_MAX)
      && flags_o.underflow_flag == $past(val < bra_pkg::SIGNED_MIN)) else $error("range flags wrong");
   zero_track_a: assert property (res_we_o |-> flags_o.zero_flag == (res_word_o == 16'h0000))
      else $error("zero flag wrong");
   carry_force_a: assert property (go && req_i.func inside {8'h40, 8'h41} |=>
      flags_o.carry_flag == ($past(req_i.func) == bra_pkg::FN_CARRY_SET)) else $error("carry force wrong");
   ptr_fault_a: assert property (go && arith && pbad |=> done_o && flags_o.fault_flag && !res_we_o)
      else $error("pointer fault missing");
   root_time_a: assert property (go && req_i.func == bra_pkg::FN_ROOT && req_i.ind_used == 3'h0
      && !rbad |=> !req_ready_o ##29 (done_o && res_we_o && req_ready_o && !flags_o.fault_flag))
      else $error("root timing wrong");
   root_fault_a: assert property (go && req_i.func == bra_pkg::FN_ROOT && rbad |->
      ##[1:31] (done_o && flags_o.fault_flag && !res_we_o)) else $error("root fault missing");
   relay_map_a: assert property ($past(rstn_i) |-> relay_bit_o ==
      (($past(relay_addr_i) == bra_pkg::RELAY_OVERFLOW && flags_o.overflow_flag)
      || ($past(relay_addr_i) == bra_pkg::RELAY_UNDERFLOW && flags_o.underflow_flag)
      || ($past(relay_addr_i) == bra_pkg::RELAY_CARRY && flags_o.carry_flag)))
      else $error("relay bit wrong");
endmodule : bra_alu_sva
`default_nettype wire

/* verif/bra_seq_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bra_seq_model (
   input  wire logic              sys_clk_i,
   input  wire logic              rstn_i,
   input  wire logic              go_i,
   input  wire bra_pkg::bra_req_t cmd_i,
   input  wire logic              ready_i,
   output logic                   valid_o,
   output bra_pkg::bra_req_t      req_o
);
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         valid_o <= 1'b0;
         req_o   <= '0;
      end else if (valid_o && ready_i) begin
         valid_o <= 1'b0;
         // Released request lines stop showing the old operands
         req_o   <= ~req_o;
      end else if (go_i && !valid_o) begin
         valid_o <= 1'b1;
         // Both radicand words travel in one request, one area
         req_o   <= cmd_i;
      end
   end
endmodule : bra_seq_model
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic                sys_clk_i = 1'b0;
   logic                rstn_i = 1'b0;
   logic                go = 1'b0;
   logic                req_valid_i;
   logic                req_ready_o;
   logic                done_o;
   logic                res_we_o;
   logic                relay_bit_o;
   logic                we_s;
   logic [15:0]         relay_addr_i = 16'h0000;
   logic [15:0]         res_word_o;
   logic [15:0]         wd_s;
   logic [15:0]         ew = 16'h0000;
   bra_pkg::bra_req_t   cmd = '0;
   bra_pkg::bra_req_t   req_i;
   bra_pkg::bra_flags_t flags_o;
   bra_pkg::bra_flags_t f_s;
   bra_pkg::bra_flags_t ef = bra_pkg::FLAGS_RESET;
   int                  bad_count = 0;
   int                  checks_done = 0;
   always #25 sys_clk_i = ~sys_clk_i;
   bra_seq_model u_seq (.sys_clk_i, .rstn_i, .go_i(go), .cmd_i(cmd), .ready_i(req_ready_o),
                        .valid_o(req_valid_i), .req_o(req_i));
   bra_alu #(.DM_WORDS(100)) u_dut (.sys_clk_i, .rstn_i, .req_valid_i, .req_i, .req_ready_o,
      .done_o, .res_we_o, .res_word_o, .flags_o, .relay_addr_i, .relay_bit_o);
   task automatic give_verdict();
      $display("mismatches %0d checks %0d", bad_count, checks_done);
      if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask : chk
   function automatic bra_pkg::bra_req_t mk(logic [7:0] fn, logic ex, logic [15:0] a, b,
                                            logic [2:0] ind = 3'h0, logic [15:0] p = 16'h0000);
      return '{func: fn, exec_cond: ex, src_a: a, src_b: b, ind_used: ind,
               ptr_a: p, ptr_b: p, ptr_r: p};
   endfunction : mk
   task automatic issue(input bra_pkg::bra_req_t r);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      cmd <= r;
      go  <= 1'b1;
      @(posedge sys_clk_i);
      go  <= 1'b0;
      do begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end while (done_o !== 1'b1 && n < 40);
      we_s = res_we_o;
      wd_s = res_word_o;
      f_s  = flags_o;
      if (done_o !== 1'b1) begin
         $display("BAD done expected 1 seen 0");
         bad_count++;
         give_verdict();
      end
   endtask : issue
   task automatic check_out(input logic [15:0] w, input logic wr);
      if (wr) ew = w;
      chk("write", {15'h0000, wr}, {15'h0000, we_s});
      chk("word", ew, wd_s);
      chk("flags", {10'h000, ef}, {10'h000, f_s});
   endtask : check_out
   task automatic relay();
      logic [15:0] ad [4] = '{bra_pkg::RELAY_OVERFLOW, bra_pkg::RELAY_UNDERFLOW,
                              bra_pkg::RELAY_CARRY, 16'h0000};
      logic        ex [4];
      ex = '{ef.overflow_flag, ef.underflow_flag, ef.carry_flag, 1'b0};
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk_i);
         relay_addr_i <= ad[i];
         @(posedge sys_clk_i);
         #1;
         chk("relay", {15'h0000, ex[i]}, {15'h0000, relay_bit_o});
      end
   endtask : relay
   task automatic arith(input logic sb, input logic [15:0] a, b, input logic cy);
      logic [16:0] s;
      int          v;
      issue(mk(cy ? bra_pkg::FN_CARRY_SET : bra_pkg::FN_CARRY_WIPE, 1'b1, 16'h0000, 16'h0000));
      ef.carry_flag = cy;
      chk("carry", {15'h0000, cy}, {15'h0000, f_s.carry_flag});
      s = sb ? {1'b0, a} - {1'b0, b} - {16'h0000, cy} : {1'b0, a} + {1'b0, b} + {16'h0000, cy};
      v = sb ? $signed(a) - $signed(b) - int'(cy) : $signed(a) + $signed(b) + int'(cy);
      issue(mk(sb ? bra_pkg::FN_BIN_SUB : bra_pkg::FN_BIN_ADD, 1'b1, a, b));
      ef = {1'b0, s[15:0] == 16'h0000, s[16], v > 32767, v < -32768, s[15]};
      check_out(s[15:0], 1'b1);
      relay();
   endtask : arith
   task automatic skip_all();
      logic [7:0] fc [5] = '{8'h50, 8'h51, 8'h72, 8'h40, 8'h41};
      for (int i = 0; i < 5; i++) begin
         issue(mk(fc[i], 1'b0, 16'h1234, 16'h4321));
         check_out(16'h0000, 1'b0);
      end
   endtask : skip_all
   task automatic root(input logic [15:0] hi, lo);
      logic [31:0] q;
      logic [15:0] e;
      int          v;
      int          r;
      q = {hi, lo};
      v = 0;
      r = 0;
      for (int i = 7; i >= 0; i--) v = v * 10 + int'(q[4*i+:4]);
      while ((r + 1) * (r + 1) <= v) r++;
      for (int i = 0; i < 4; i++) begin
         e[4*i+:4] = 4'(r % 10);
         r = r / 10;
      end
      issue(mk(bra_pkg::FN_ROOT, 1'b1, lo, hi));
      ef.fault_flag = 1'b0;
      ef.zero_flag  = e == 16'h0000;
      check_out(e, 1'b1);
   endtask : root
   task automatic fault(input bra_pkg::bra_req_t r);
      issue(r);
      ef.fault_flag = 1'b1;
      check_out(16'h0000, 1'b0);
   endtask : fault
   task automatic ptr_edge();
      logic [15:0] w;
      w = 16'h0005 + {15'h0000, ef.carry_flag};
      issue(mk(bra_pkg::FN_BIN_ADD, 1'b1, 16'h0002, 16'h0003, 3'h7, 16'h0099));
      ef = 6'h00;
      check_out(w, 1'b1);
   endtask : ptr_edge
   initial begin
      repeat (5) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      relay();
      arith(1'b0, 16'h62E9, 16'hCC3B, 1'b0);
      arith(1'b0, 16'hA6E2, 16'h80C5, 1'b0);
      arith(1'b0, 16'hFFFF, 16'h0000, 1'b1);
      arith(1'b0, 16'h7FFF, 16'h0000, 1'b1);
      arith(1'b1, 16'h7544, 16'hC47A, 1'b0);
      arith(1'b1, 16'h8AD0, 16'h0BB8, 1'b0);
      arith(1'b1, 16'hF8C5, 16'h7A03, 1'b0);
      arith(1'b1, 16'h0005, 16'h0005, 1'b1);
      arith(1'b1, 16'h0005, 16'h0004, 1'b1);
      skip_all();
      root(16'h6017, 16'h0000);
      root(16'h9999, 16'h9999);
      root(16'h0000, 16'h0003);
      root(16'h0001, 16'h0000);
      root(16'h0000, 16'h0000);
      fault(mk(bra_pkg::FN_ROOT, 1'b1, 16'h00A0, 16'h0000));
      fault(mk(bra_pkg::FN_ROOT, 1'b1, 16'h0000, 16'h1F00));
      fault(mk(bra_pkg::FN_BIN_ADD, 1'b1, 16'h0001, 16'h0001, 3'h1, 16'h12A4));
      fault(mk(bra_pkg::FN_BIN_SUB, 1'b1, 16'h0001, 16'h0001, 3'h4, 16'h0100));
      ptr_edge();
      give_verdict();
   end
endmodule : testbench
bind bra_alu bra_alu_sva #(.DM_WORDS(DM_WORDS)) u_sva (.sys_clk_i, .rstn_i, .req_valid_i, .req_i,
   .req_ready_o, .done_o, .res_we_o, .res_word_o, .flags_o, .relay_addr_i, .relay_bit_o);
`default_nettype wire
